// >>> logic/sdas_core.sv
// serial byte engine with own address match, state codes and register slave
`timescale 1ns/1ps
// How it works
// RL1 - data register accessible while event flag set
// RL2 - software avoids data register while shifting
// RL3 - bytes go out most significant first
// RL4 - first received bit lands in bit seven
// RL5 - bus line shifts in while sending
// RL6 - lost arbitration continues as slave receiver
// RL7 - seven address bits compared, bit seven first
// RL8 - bit zero enables general call acceptance
// RL9 - own address unused while acting master
// RL10 - eight-bit code names each reportable state
// RL11 - code low three bits read zero
// RL12 - code valid only while event flag set
// RL13 - software never writes the code register
// RL14 - new state: code, flag, clock held; the stop report (C_SR_STOP) sets code and flag but leaves the clock free
module sdas_core #(
	parameter int HALF_CYC = sdas_pkg::SCL_HALF_CYC
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// serial clock pin
	input  wire logic        sclSense,
	output logic             sclLevel,
	output logic             sclOe,
	// serial data pin
	input  wire logic        sdaSense,
	output logic             sdaLevel,
	output logic             sdaOe,
	// interrupt
	output logic             irq
);
	localparam int EVN = sdas_pkg::EV_NUM;

	// whole state of the block
	typedef struct packed {
		sdas_pkg::sdas_state_e fsm;     // sequencer state
		logic                  ena;     // interface_enable
		logic                  si;      // state event flag
		logic                  sta;     // start request
		logic                  sto;     // stop request
		logic                  aa;      // acknowledge to send
		logic                  busy;    // bus between start and stop
		logic [7:0]            shReg;   // serial_byte_reg
		logic [7:0]            code;    // state_code_reg
		logic [7:0]            ownAdr;  // own_address_reg
		logic [3:0]            bitCnt;  // bits of current byte
		logic [1:0]            mPhase;  // master sub step
		logic [7:0]            div;     // half period timer
		logic                  master;  // acting as master
		logic                  txMode;  // sending current byte
		logic                  mRead;   // master read session
		logic                  addrPh;  // byte is an address
		logic                  gcSess;  // general call session
		logic                  arbLost; // lost arbitration
		logic                  addrd;   // addressed as slave
		logic                  ackBit;  // acknowledge seen
		logic                  sclLow;  // pull clock low
		logic                  sdaLow;  // pull data low
		logic                  sclP;    // previous clock sample
		logic                  sdaP;    // previous data sample
		logic [EVN-1:0]        iStat;   // sticky events
		logic [EVN-1:0]        iMask;   // event mask
		logic                  ack;     // bus acknowledge
		logic [31:0]           rdData;  // read data
	} sdas_regs_s;

	sdas_regs_s     r_ff;    // registered state
	sdas_regs_s     nxt_r;   // next state
	logic [1:0]     syncLvl; // {scl, sda} after synchroniser
	logic           sclS;    // synchronised clock
	logic           sdaS;    // synchronised data
	logic           sclRise; // clock rising
	logic           sclFall; // clock falling
	logic           startDet;// start seen
	logic           stopDet; // stop seen
	logic           tick;    // half period elapsed
	logic           arbHit;  // master sent one, bus shows zero
	logic           byteEnd; // slave eighth clock falling
	logic [7:0]     shNext;  // shift register with line bit in
	logic [7:0]     rdByte;  // read mux
	logic [7:0]     idx;     // register index
	logic           busReq;  // first cycle of a bus access
	logic           busDone; // acknowledged cycle
	logic [EVN-1:0] ev;      // events this cycle

	//////////////////////////////////////////////////////////////////
	// pin levels pass two flip-flops first
	sdas_sync #(
		.W(2)
	) u_sync (
		.core_clk(core_clk),
		.nrst    (nrst),
		.pinLvl  ({sclSense, sdaSense}),
		.syncLvl (syncLvl)
	);

	assign sclS     = syncLvl[1];
	assign sdaS     = syncLvl[0];
	assign sclRise  = sclS & ~r_ff.sclP;
	assign sclFall  = ~sclS & r_ff.sclP;
	// data edge while clock stays high
	assign startDet = sclS & r_ff.sclP & r_ff.sdaP & ~sdaS;
	assign stopDet  = sclS & r_ff.sclP & ~r_ff.sdaP & sdaS;
	assign shNext   = {r_ff.shReg[6:0], sdaS};
	assign arbHit   = r_ff.txMode & r_ff.shReg[7] & ~sdaS;
	assign byteEnd  = (r_ff.fsm == sdas_pkg::ST_SBITS) & sclFall & (r_ff.bitCnt == 4'h8);
	assign idx      = adr_i[9:2];
	assign busReq   = cyc_i & stb_i & ~r_ff.ack;
	assign busDone  = cyc_i & stb_i & r_ff.ack;

	//////////////////////////////////////////////////////////////////
	// read mux
	always_comb begin
		case (idx)
			sdas_pkg::IDX_CTRL: begin
				rdByte = {r_ff.busy, r_ff.ena, r_ff.sta, r_ff.sto, r_ff.si, r_ff.aa, 2'h0};
			end
			// RL11 RL12 code valid with flag
			sdas_pkg::IDX_STATE: begin
				rdByte = r_ff.si ? r_ff.code : sdas_pkg::C_IDLE;
			end
			// RL1 byte readable any time
			sdas_pkg::IDX_DATA:  rdByte = r_ff.shReg;
			sdas_pkg::IDX_OWN:   rdByte = r_ff.ownAdr;
			sdas_pkg::IDX_ISTAT: rdByte = {4'h0, r_ff.iStat};
			sdas_pkg::IDX_IMASK: rdByte = {4'h0, r_ff.iMask};
			// unmapped reads as zero
			default:             rdByte = 8'h00;
		endcase
	end

	//////////////////////////////////////////////////////////////////
	// next state: bus writes first, link events after so hardware wins
	always_comb begin
		nxt_r = r_ff;
		ev    = '0;
		tick  = 1'h0;
		nxt_r.ack  = busReq;
		nxt_r.sclP = sclS;
		nxt_r.sdaP = sdaS;
		if (busReq) begin
			nxt_r.rdData = {24'h000000, rdByte};
		end
		// writes land on the acknowledged edge
		if (busDone && we_i && sel_i[0]) begin
			case (idx)
				sdas_pkg::IDX_CTRL: begin
					nxt_r.ena = dat_i[sdas_pkg::CTL_ENA];
					nxt_r.sta = dat_i[sdas_pkg::CTL_STA];
					nxt_r.sto = dat_i[sdas_pkg::CTL_STO];
					nxt_r.aa  = dat_i[sdas_pkg::CTL_AA];
					// flag only clears from software
					if (!dat_i[sdas_pkg::CTL_SI]) begin
						nxt_r.si = 1'h0;
					end
				end
				// RL1 byte to send
				sdas_pkg::IDX_DATA:  nxt_r.shReg = dat_i[7:0];
				sdas_pkg::IDX_OWN:   nxt_r.ownAdr = dat_i[7:0];
				sdas_pkg::IDX_IMASK: nxt_r.iMask = dat_i[EVN-1:0];
				// RL13 code register has no write path
				default: begin
				end
			endcase
		end
		// read of status clears it
		if (busDone && !we_i && idx == sdas_pkg::IDX_ISTAT) begin
			nxt_r.iStat = '0;
		end
		// half period timer, free running
		if (r_ff.div == 8'(HALF_CYC - 1)) begin
			tick      = 1'h1;
			nxt_r.div = 8'h00;
		end else begin
			nxt_r.div = r_ff.div + 8'h01;
		end
		// bus busy tracking
		if (startDet) begin
			nxt_r.busy = 1'h1;
		end else if (stopDet) begin
			nxt_r.busy = 1'h0;
			ev[sdas_pkg::EV_STOP] = 1'h1;
		end

		unique case (r_ff.fsm)
			// wait for a start or a request to master
			sdas_pkg::ST_IDLE: begin
				if (r_ff.sta && !r_ff.busy && !r_ff.si && !startDet) begin
					nxt_r.fsm    = sdas_pkg::ST_MSTART;
					nxt_r.mPhase = 2'h0;
				end
			end
			// slave byte on the other party's clock
			sdas_pkg::ST_SBITS: begin
				if (sclRise) begin
					// RL4 RL5 line bit enters at bit zero
					nxt_r.shReg  = shNext;
					nxt_r.bitCnt = r_ff.bitCnt + 4'h1;
				end
				if (byteEnd) begin
					nxt_r.fsm = sdas_pkg::ST_SACK;
					if (r_ff.addrPh) begin
						// RL7 RL8 RL9 address compare, slave only
						if (!r_ff.master && r_ff.shReg[7:1] != 7'h00 &&
						    r_ff.shReg[7:1] == r_ff.ownAdr[7:sdas_pkg::OWN_LSB]) begin
							nxt_r.sdaLow = 1'h1;
							nxt_r.addrd  = 1'h1;
							nxt_r.gcSess = 1'h0;
							nxt_r.txMode = r_ff.shReg[0];
							ev[sdas_pkg::EV_MATCH] = 1'h1;
						end else if (!r_ff.master && r_ff.shReg == 8'h00 &&
						             r_ff.ownAdr[sdas_pkg::OWN_GC]) begin
							nxt_r.sdaLow = 1'h1;
							nxt_r.addrd  = 1'h1;
							nxt_r.gcSess = 1'h1;
							nxt_r.txMode = 1'h0;
							ev[sdas_pkg::EV_MATCH] = 1'h1;
						end else if (r_ff.arbLost) begin
							nxt_r.fsm = sdas_pkg::ST_HOLD;
						end else begin
							// not for us: wait for the next start
							nxt_r.fsm = sdas_pkg::ST_IDLE;
						end
					end else if (r_ff.arbLost) begin
						nxt_r.fsm = sdas_pkg::ST_HOLD;
					end else begin
						// receiver answers with aa, sender lets go
						nxt_r.sdaLow = ~r_ff.txMode & r_ff.aa;
					end
					// RL6 lost byte already sits in the register
					if (nxt_r.fsm == sdas_pkg::ST_HOLD) begin
						nxt_r.sclLow = 1'h1;
						nxt_r.si     = 1'h1;
						nxt_r.code   = sdas_pkg::C_ARB;
						nxt_r.addrd  = 1'h0;
						ev[sdas_pkg::EV_SI] = 1'h1;
					end
				end else if (sclFall && r_ff.txMode) begin
					// RL3 next bit out, top bit first
					nxt_r.sdaLow = ~r_ff.shReg[7];
				end
			end
			// slave acknowledge clock
			sdas_pkg::ST_SACK: begin
				if (sclRise) begin
					nxt_r.ackBit = ~sdaS;
				end
				if (sclFall) begin
					// RL14 report and stretch the clock
					nxt_r.sdaLow = 1'h0;
					nxt_r.sclLow = 1'h1;
					nxt_r.si     = 1'h1;
					nxt_r.fsm    = sdas_pkg::ST_HOLD;
					ev[sdas_pkg::EV_SI] = 1'h1;
					// RL10 one code per state
					if (r_ff.addrPh) begin
						nxt_r.addrPh = 1'h0;
						if (r_ff.gcSess) begin
							nxt_r.code = r_ff.arbLost ? sdas_pkg::C_SR_GCARB : sdas_pkg::C_SR_GC;
						end else if (r_ff.txMode) begin
							nxt_r.code = r_ff.arbLost ? sdas_pkg::C_ST_RARB : sdas_pkg::C_ST_R;
						end else begin
							nxt_r.code = r_ff.arbLost ? sdas_pkg::C_SR_WARB : sdas_pkg::C_SR_W;
						end
					end else if (r_ff.txMode) begin
						nxt_r.code  = r_ff.ackBit ? sdas_pkg::C_ST_DACK : sdas_pkg::C_ST_DNAK;
						nxt_r.addrd = r_ff.ackBit;
					end else if (r_ff.gcSess) begin
						nxt_r.code  = r_ff.ackBit ? sdas_pkg::C_SR_GACK : sdas_pkg::C_SR_GNAK;
						nxt_r.addrd = r_ff.ackBit;
					end else begin
						nxt_r.code  = r_ff.ackBit ? sdas_pkg::C_SR_DACK : sdas_pkg::C_SR_DNAK;
						nxt_r.addrd = r_ff.ackBit;
					end
				end
			end
			// software services the state; clock held low meanwhile
			sdas_pkg::ST_HOLD: begin
				if (!nxt_r.si) begin
					nxt_r.bitCnt  = 4'h0;
					nxt_r.mPhase  = 2'h0;
					nxt_r.arbLost = 1'h0;
					if (r_ff.master) begin
						if (nxt_r.sto) begin
							nxt_r.fsm = sdas_pkg::ST_MSTOP;
						end else if (nxt_r.sta) begin
							nxt_r.fsm = sdas_pkg::ST_MSTART;
						end else begin
							nxt_r.fsm    = sdas_pkg::ST_MBITS;
							nxt_r.txMode = r_ff.addrPh | ~r_ff.mRead;
						end
					end else begin
						nxt_r.sclLow = 1'h0;
						if (r_ff.addrd) begin
							nxt_r.fsm    = sdas_pkg::ST_SBITS;
							nxt_r.sdaLow = r_ff.txMode & ~r_ff.shReg[7];
						end else begin
							nxt_r.fsm = sdas_pkg::ST_IDLE;
						end
					end
				end
			end
			// start or repeated start: free lines, then data low under high clock
			sdas_pkg::ST_MSTART: begin
				unique case (r_ff.mPhase)
					2'h0: begin
						nxt_r.sdaLow = 1'h0;
						if (tick) nxt_r.mPhase = 2'h1;
					end
					2'h1: begin
						nxt_r.sclLow = 1'h0;
						if (tick && sclS) nxt_r.mPhase = 2'h2;
					end
					2'h2: begin
						nxt_r.sdaLow = 1'h1;
						if (tick) nxt_r.mPhase = 2'h3;
					end
					2'h3: begin
						// RL14 start reported with clock held
						nxt_r.sclLow = 1'h1;
						nxt_r.si     = 1'h1;
						nxt_r.code   = r_ff.master ? sdas_pkg::C_RSTART : sdas_pkg::C_START;
						nxt_r.master = 1'h1;
						nxt_r.addrPh = 1'h1;
						nxt_r.fsm    = sdas_pkg::ST_HOLD;
						ev[sdas_pkg::EV_SI] = 1'h1;
					end
				endcase
			end
			// master byte: low half drives, high half samples
			sdas_pkg::ST_MBITS: begin
				if (!r_ff.mPhase[0]) begin
					nxt_r.sclLow = 1'h1;
					// RL3 top bit on the line
					nxt_r.sdaLow = r_ff.txMode & ~r_ff.shReg[7];
					if (tick) nxt_r.mPhase = 2'h1;
				end else begin
					nxt_r.sclLow = 1'h0;
					if (tick && sclS) begin
						// RL5 bus bit shifts in as ours shifts out
						nxt_r.shReg  = shNext;
						nxt_r.bitCnt = r_ff.bitCnt + 4'h1;
						nxt_r.mPhase = 2'h0;
						if (arbHit) begin
							// RL6 hand over to slave receive mid byte
							nxt_r.master  = 1'h0;
							nxt_r.arbLost = 1'h1;
							nxt_r.txMode  = 1'h0;
							nxt_r.sdaLow  = 1'h0;
							nxt_r.fsm     = sdas_pkg::ST_SBITS;
							ev[sdas_pkg::EV_ARB] = 1'h1;
						end else begin
							nxt_r.sclLow = 1'h1;
							if (r_ff.bitCnt == 4'h7) nxt_r.fsm = sdas_pkg::ST_MACK;
						end
					end
				end
			end
			// master acknowledge clock
			sdas_pkg::ST_MACK: begin
				if (!r_ff.mPhase[0]) begin
					nxt_r.sclLow = 1'h1;
					nxt_r.sdaLow = ~r_ff.txMode & r_ff.aa;
					if (tick) nxt_r.mPhase = 2'h1;
				end else begin
					nxt_r.sclLow = 1'h0;
					if (tick && sclS) begin
						// RL14 byte done: code, flag, clock low
						nxt_r.sclLow = 1'h1;
						nxt_r.sdaLow = 1'h0;
						nxt_r.si     = 1'h1;
						nxt_r.fsm    = sdas_pkg::ST_HOLD;
						ev[sdas_pkg::EV_SI] = 1'h1;
						if (r_ff.addrPh) begin
							nxt_r.addrPh = 1'h0;
							nxt_r.mRead  = r_ff.shReg[0];
							if (r_ff.shReg[0]) begin
								nxt_r.code = ~sdaS ? sdas_pkg::C_MR_AACK : sdas_pkg::C_MR_ANAK;
							end else begin
								nxt_r.code = ~sdaS ? sdas_pkg::C_MT_AACK : sdas_pkg::C_MT_ANAK;
							end
						end else if (r_ff.txMode) begin
							nxt_r.code = ~sdaS ? sdas_pkg::C_MT_DACK : sdas_pkg::C_MT_DNAK;
						end else begin
							nxt_r.code = ~sdaS ? sdas_pkg::C_MR_DACK : sdas_pkg::C_MR_DNAK;
						end
					end
				end
			end
			// stop: data low, clock high, then data high
			sdas_pkg::ST_MSTOP: begin
				if (r_ff.mPhase == 2'h0) begin
					nxt_r.sclLow = 1'h1;
					nxt_r.sdaLow = 1'h1;
					if (tick) nxt_r.mPhase = 2'h1;
				end else if (r_ff.mPhase == 2'h1) begin
					nxt_r.sclLow = 1'h0;
					if (tick && sclS) nxt_r.mPhase = 2'h2;
				end else begin
					nxt_r.sdaLow = 1'h0;
					if (tick) begin
						nxt_r.master = 1'h0;
						nxt_r.sto    = 1'h0;
						nxt_r.fsm    = sdas_pkg::ST_IDLE;
					end
				end
			end
		endcase

		// slave side framing; a late start loses the next address if unserviced
		if (!r_ff.master && (r_ff.fsm == sdas_pkg::ST_IDLE ||
		    r_ff.fsm == sdas_pkg::ST_SBITS || r_ff.fsm == sdas_pkg::ST_SACK)) begin
			if (startDet || stopDet) begin
				nxt_r.sdaLow = 1'h0;
				nxt_r.sclLow = 1'h0;
				nxt_r.fsm    = startDet ? sdas_pkg::ST_SBITS : sdas_pkg::ST_IDLE;
				nxt_r.addrPh = 1'h1;
				nxt_r.bitCnt = 4'h0;
				nxt_r.txMode = 1'h0;
				if (r_ff.addrd) begin
					// no stretch here: clock is high during the condition
					nxt_r.si    = 1'h1;
					nxt_r.code  = sdas_pkg::C_SR_STOP;
					nxt_r.addrd = 1'h0;
					ev[sdas_pkg::EV_SI] = 1'h1;
				end
			end
		end
		// disabled: let go of both lines
		if (!r_ff.ena) begin
			nxt_r.fsm    = sdas_pkg::ST_IDLE;
			nxt_r.sclLow = 1'h0;
			nxt_r.sdaLow = 1'h0;
			nxt_r.master = 1'h0;
			nxt_r.addrd  = 1'h0;
		end
		// events set after any clear, so they are never lost
		nxt_r.iStat = nxt_r.iStat | ev;
	end

	//////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			r_ff        <= '0;
			r_ff.fsm    <= sdas_pkg::ST_IDLE;
			r_ff.shReg  <= sdas_pkg::DATA_RST;
			r_ff.ownAdr <= sdas_pkg::OWN_RST;
			r_ff.iMask  <= sdas_pkg::MASK_RST;
			r_ff.sclP   <= 1'h1;
			r_ff.sdaP   <= 1'h1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// open drain: level is always low, enable pulls
	assign sclLevel = 1'h0;
	assign sdaLevel = 1'h0;
	assign sclOe    = r_ff.sclLow;
	assign sdaOe    = r_ff.sdaLow;
	assign dat_o    = r_ff.rdData;
	assign ack_o    = r_ff.ack;
	assign irq      = |(r_ff.iStat & r_ff.iMask);

	//////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	a_flag_holds_clock: // RL14
	assert property ((r_ff.si && r_ff.fsm == sdas_pkg::ST_HOLD && r_ff.code != sdas_pkg::C_SR_STOP)
		|-> sclOe) else $error("clock not held while event flag set");
	a_code_low_zero: // RL11
	assert property (r_ff.si |-> r_ff.code[2:0] == 3'h0) else $error("code not a multiple of eight");
	a_code_read_idle: // RL12
	assert property ((busReq && !we_i && idx == sdas_pkg::IDX_STATE && !r_ff.si)
		|=> ack_o && dat_o[7:0] == sdas_pkg::C_IDLE) else $error("stale code visible");
	a_data_read_back: // RL1
	assert property ((busReq && !we_i && idx == sdas_pkg::IDX_DATA)
		|=> ack_o && dat_o == {24'h000000, $past(r_ff.shReg)}) else $error("data read wrong");
	a_msb_first_out: // RL3
	assert property ((r_ff.fsm == sdas_pkg::ST_MBITS && r_ff.txMode && r_ff.mPhase[0])
		|-> sdaOe == ~r_ff.shReg[7]) else $error("sent bit is not the top bit");
	a_line_shifts_in: // RL5
	assert property ((r_ff.ena && r_ff.fsm == sdas_pkg::ST_SBITS && sclRise && !startDet)
		|=> r_ff.shReg == $past(shNext)) else $error("line bit not shifted in");
	a_arb_to_slave: // RL6
	assert property ((r_ff.ena && r_ff.fsm == sdas_pkg::ST_MBITS && r_ff.mPhase[0] && tick && sclS
		&& arbHit) |=> !r_ff.master && r_ff.fsm == sdas_pkg::ST_SBITS && r_ff.arbLost)
		else $error("arbitration loss not handed to slave");
	a_gc_ignored: // RL8
	assert property ((r_ff.ena && byteEnd && r_ff.addrPh && r_ff.shReg == 8'h00 && !r_ff.arbLost
		&& !r_ff.ownAdr[0]) |=> r_ff.fsm == sdas_pkg::ST_IDLE && !sdaOe)
		else $error("general call answered while disabled");
	a_own_match_ack: // RL7
	assert property ((r_ff.ena && byteEnd && r_ff.addrPh && !r_ff.master && r_ff.shReg[7:1] != 7'h00
		&& r_ff.shReg[7:1] == r_ff.ownAdr[7:1]) |=> sdaOe[*2]) else $error("own address not acked");
	a_master_no_match: // RL9
	assert property (r_ff.master |-> !ev[sdas_pkg::EV_MATCH]) else $error("address match as master");
	a_ack_one_cycle:
	assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
endmodule

// >>> logic/sdas_pkg.sv
// shared constants and types for the serial data, address and state block
package sdas_pkg;
	// timing: core clock and half period of a generated serial clock
	localparam int CLK_NS       = 40;
	localparam int SCL_HALF_NS  = 160;
	localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_CTRL  = 8'hC0;
	localparam logic [7:0] IDX_STATE = 8'hC1;
	localparam logic [7:0] IDX_DATA  = 8'hC2;
	localparam logic [7:0] IDX_OWN   = 8'hC3;
	localparam logic [7:0] IDX_ISTAT = 8'hC4;
	localparam logic [7:0] IDX_IMASK = 8'hC5;

	// bus_control_reg fields
	localparam int CTL_BUSY = 7;
	localparam int CTL_ENA  = 6;
	localparam int CTL_STA  = 5;
	localparam int CTL_STO  = 4;
	localparam int CTL_SI   = 3;
	localparam int CTL_AA   = 2;

	// own_address_reg fields
	localparam int OWN_GC  = 0;
	localparam int OWN_LSB = 1;

	// reset values
	localparam logic [7:0] OWN_RST  = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [3:0] MASK_RST = 4'h0;

	// interrupt event bits
	localparam int EV_SI    = 0;
	localparam int EV_ARB   = 1;
	localparam int EV_STOP  = 2;
	localparam int EV_MATCH = 3;
	localparam int EV_NUM   = 4;

	// state codes, all multiples of eight
	localparam logic [7:0] C_START    = 8'h08;
	localparam logic [7:0] C_RSTART   = 8'h10;
	localparam logic [7:0] C_MT_AACK  = 8'h18;
	localparam logic [7:0] C_MT_ANAK  = 8'h20;
	localparam logic [7:0] C_MT_DACK  = 8'h28;
	localparam logic [7:0] C_MT_DNAK  = 8'h30;
	localparam logic [7:0] C_ARB      = 8'h38;
	localparam logic [7:0] C_MR_AACK  = 8'h40;
	localparam logic [7:0] C_MR_ANAK  = 8'h48;
	localparam logic [7:0] C_MR_DACK  = 8'h50;
	localparam logic [7:0] C_MR_DNAK  = 8'h58;
	localparam logic [7:0] C_SR_W     = 8'h60;
	localparam logic [7:0] C_SR_WARB  = 8'h68;
	localparam logic [7:0] C_SR_GC    = 8'h70;
	localparam logic [7:0] C_SR_GCARB = 8'h78;
	localparam logic [7:0] C_SR_DACK  = 8'h80;
	localparam logic [7:0] C_SR_DNAK  = 8'h88;
	localparam logic [7:0] C_SR_GACK  = 8'h90;
	localparam logic [7:0] C_SR_GNAK  = 8'h98;
	localparam logic [7:0] C_SR_STOP  = 8'hA0;
	localparam logic [7:0] C_ST_R     = 8'hA8;
	localparam logic [7:0] C_ST_RARB  = 8'hB0;
	localparam logic [7:0] C_ST_DACK  = 8'hB8;
	localparam logic [7:0] C_ST_DNAK  = 8'hC0;
	localparam logic [7:0] C_IDLE     = 8'hF8;

	// interface sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_SBITS, ST_SACK, ST_HOLD, ST_MSTART, ST_MBITS, ST_MACK, ST_MSTOP
	} sdas_state_e;
endpackage

// >>> logic/sdas_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module sdas_sync #(
	parameter int W = 2
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         nrst,
	// levels
	input  wire logic [W-1:0] pinLvl,
	output logic      [W-1:0] syncLvl
);
	// both stages in one state word
	typedef struct packed {
		logic [W-1:0] stage1;
		logic [W-1:0] stage2;
	} sdas_sync_s;

	sdas_sync_s r_ff;   // registered stages
	sdas_sync_s nxt_r;  // next stages

	//////////////////////////////////////////////////////////////////
	// first stage is read only by the second
	always_comb begin
		nxt_r.stage1 = pinLvl;
		nxt_r.stage2 = r_ff.stage1;
	end

	// idle bus level is high, so reset to ones
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			r_ff <= '1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign syncLvl = r_ff.stage2;
endmodule

// >>> verif/sdas_bus_peer.sv
// far-side bus master model driving the shared serial clock and data wires
`timescale 1ns/1ps
module sdas_bus_peer (
	// wire levels
	input  wire logic scl,
	input  wire logic sda,
	// pull-low enables, wires float high through the pull-up when released
	output logic      pullScl,
	output logic      pullSda
);
	initial begin
		pullScl = 1'b0;
		pullSda = 1'b0;
	end
	// one bit: data set 40 ns before the clock is released, sampled mid-high; waiting on scl honours stretching
	// changes land on core clock edges, so they go in as non-blocking updates
	task automatic bitIo(input logic b, output logic seen);
		#120 pullSda <= !b;
		#40 pullScl <= 1'b0;
		wait (scl);
		#80 seen = sda;
		#80 pullScl <= 1'b1;
	endtask
	// start from a free bus
	task automatic start();
		pullSda <= 1'b1;
		#160 pullScl <= 1'b1;
	endtask
	// byte out msb first, ninth clock returns the acknowledge
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitIo(b[i], s);
		end
		bitIo(1'b1, s);
		ack = !s;
	endtask
	// stop: data rises while the clock is high
	task automatic stop();
		#120 pullSda <= 1'b1;
		#40 pullScl <= 1'b0;
		wait (scl);
		#160 pullSda <= 1'b0;
	endtask
endmodule

// >>> verif/sdas_tb.sv
// self-checking bench: register bus accesses and slave-side serial traffic
`timescale 1ns/1ps
module tb;
	logic        core_clk = 0;
	logic        nrst = 0;
	logic        cyc = 0, stb = 0, we = 0;
	logic [9:0]  adr = '0;
	logic [31:0] datI = '0, datO;
	logic        ack, sclOe, sdaOe, irq, pScl, pSda, gotAck;
	logic [7:0]  rdv;
	int          miscompares = 0, numChecks = 0;
	// open-drain wires with pull-up
	wire scl = !(sclOe | pScl);
	wire sda = !(sdaOe | pSda);
	always #20 core_clk = !core_clk;
	sdas_core #(.HALF_CYC(2)) uut (.core_clk(core_clk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(datI), .dat_o(datO), .ack_o(ack),
		.sclSense(scl), .sclLevel(), .sclOe(sclOe), .sdaSense(sda), .sdaLevel(), .sdaOe(sdaOe),
		.irq(irq));
	sdas_bus_peer peer (.scl(scl), .sda(sda), .pullScl(pScl), .pullSda(pSda));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		numChecks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	// classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge core_clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; datI <= {24'h0, wd};
		do @(posedge core_clk); while (ack !== 1'b1);
		rdv = datO[7:0];
		cyc <= 1'b0; stb <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
		wb(1'b0, idx, 8'h00);
		chk(nm, e, rdv);
	endtask
	// bounded wait for the interrupt line
	task automatic waitIrq();
		for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge core_clk);
		chk("irq", 8'h01, {7'h0, irq});
	endtask
	task automatic final_report();
		if (miscompares == 0 && numChecks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchdog, far beyond the expected few tens of microseconds
	initial begin
		#2000000;
		miscompares++;
		final_report();
	end
	// main sequence; the state code register is never written
	initial begin
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		rdc("own reset", sdas_pkg::IDX_OWN, sdas_pkg::OWN_RST);
		rdc("code idle", sdas_pkg::IDX_STATE, sdas_pkg::C_IDLE);
		rdc("unmapped", 8'h10, 8'h00);
		wb(1'b1, sdas_pkg::IDX_OWN, 8'hA4);
		wb(1'b1, sdas_pkg::IDX_IMASK, 8'h01);
		wb(1'b1, sdas_pkg::IDX_CTRL, 8'h44);
		peer.start();
		peer.sendByte(8'hA4, gotAck);
		chk("addr ack", 8'h01, {7'h0, gotAck});
		waitIrq();
		chk("scl held", 8'h01, {7'h0, sclOe});
		rdc("code addr", sdas_pkg::IDX_STATE, sdas_pkg::C_SR_W);
		rdc("istat", sdas_pkg::IDX_ISTAT, 8'h09);
		rdc("istat clr", sdas_pkg::IDX_ISTAT, 8'h00);
		wb(1'b1, sdas_pkg::IDX_CTRL, 8'h44);
		peer.sendByte(8'h96, gotAck);
		chk("data ack", 8'h01, {7'h0, gotAck});
		waitIrq();
		rdc("code data", sdas_pkg::IDX_STATE, sdas_pkg::C_SR_DACK);
		// data read only while the flag is set
		rdc("data", sdas_pkg::IDX_DATA, 8'h96);
		rdc("istat2", sdas_pkg::IDX_ISTAT, 8'h01);
		wb(1'b1, sdas_pkg::IDX_CTRL, 8'h44);
		peer.stop();
		waitIrq();
		rdc("code stop", sdas_pkg::IDX_STATE, sdas_pkg::C_SR_STOP);
		wb(1'b1, sdas_pkg::IDX_IMASK, 8'h00);
		// mask lands on the ack edge; look one edge later
		@(posedge core_clk);
		chk("irq masked", 8'h00, {7'h0, irq});
		wb(1'b1, sdas_pkg::IDX_IMASK, 8'h01);
		wb(1'b1, sdas_pkg::IDX_CTRL, 8'h44);
		wb(1'b0, sdas_pkg::IDX_ISTAT, 8'h00);
		peer.start();
		peer.sendByte(8'h00, gotAck);
		chk("gc off", 8'h00, {7'h0, gotAck});
		peer.stop();
		wb(1'b1, sdas_pkg::IDX_OWN, 8'hA5);
		wb(1'b0, sdas_pkg::IDX_ISTAT, 8'h00);
		peer.start();
		peer.sendByte(8'h00, gotAck);
		chk("gc on", 8'h01, {7'h0, gotAck});
		waitIrq();
		rdc("code gc", sdas_pkg::IDX_STATE, sdas_pkg::C_SR_GC);
		rdc("istat gc", sdas_pkg::IDX_ISTAT, 8'h09);
		wb(1'b1, sdas_pkg::IDX_CTRL, 8'h44);
		peer.stop();
		waitIrq();
		rdc("istat stop", sdas_pkg::IDX_ISTAT, 8'h05);
		// master session to our own address: it must stay unanswered
		wb(1'b1, sdas_pkg::IDX_OWN, 8'h5A);
		wb(1'b1, sdas_pkg::IDX_CTRL, 8'h64);
		waitIrq();
		rdc("code start", sdas_pkg::IDX_STATE, sdas_pkg::C_START);
		rdc("istat start", sdas_pkg::IDX_ISTAT, 8'h01);
		wb(1'b1, sdas_pkg::IDX_DATA, 8'h5A);
		wb(1'b1, sdas_pkg::IDX_CTRL, 8'h44);
		waitIrq();
		chk("mscl held", 8'h01, {7'h0, sclOe});
		rdc("code anak", sdas_pkg::IDX_STATE, sdas_pkg::C_MT_ANAK);
		rdc("bus byte", sdas_pkg::IDX_DATA, 8'h5A);
		rdc("istat nomatch", sdas_pkg::IDX_ISTAT, 8'h01);
		wb(1'b1, sdas_pkg::IDX_CTRL, 8'h54);
		repeat (20) @(posedge core_clk);
		rdc("stop done", sdas_pkg::IDX_CTRL, 8'h44);
		final_report();
	end
endmodule
